/* File: verilog/eisp_top.sv */
// External interrupt sensitivity, priority registers and request delivery
//
// Summary of operation
// - Bits 7:6 of the sense control register qualify the port B low nibble and port B bit 4 requests.
// - Without inversion, codes 00/01/10/11 mean falling+low, rising, falling, both edges.
// - Port B polarity inverts only the port B low nibble request; code 11 stays both edges.
// - Bits 4:3 qualify the port A low nibble and port F requests with the same codes.
// - Port A polarity (bit 2) inverts only the port A low nibble request, not port F.
// - A sense field write lands only while both CPU level bits are 1.
// - Polarity bits change only at CPU level 3; software disables interrupts first.
// - The sense control register resets to zero.
// - Priority registers sit at 0x24..0x27 and the sense register at 0x28; priority bits reset to 1.
// - Writing a changed sense or polarity value clears pending external requests.
// - A priority pair written as 1,0 keeps its previous value; other pairs update.
// - Bits 7:4 of the fourth priority register are read-only ones.
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module eisp_top
  import eisp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire eisp_pins_t i_pins,
  input wire logic [3:0] i_req_ack,
  input wire logic [1:0] i_cpu_level,
  output eisp_req_t o_ext_req,
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] prio_q [4];
  logic [7:0] prio_d [4];
  logic [7:0] sense_q;
  logic [7:0] sense_d;
  logic [3:0] pend_q;
  logic [3:0] pend_d;
  logic [3:0] stat_q;
  logic [3:0] stat_d;
  logic [3:0] mask_q;
  logic [3:0] mask_d;
  eisp_req_t req_q;
  eisp_req_t req_d;
  logic irq_q;
  logic irq_d;
  logic [7:0] rdata;
  logic hit;
  logic wr;
  logic rd;
  logic [7:0] wbyte;
  logic at_level3;
  logic [3:0] edge_ev;
  logic [3:0] level_ev;

  assign wbyte = i_pwdata[7:0];
  assign at_level3 = &i_cpu_level;

  // Register index to byte address: one aligned word per register
  function automatic logic [31:0] word_addr(input logic [31:0] idx);
    return {idx[29:0], 2'b00};
  endfunction

  function automatic logic [2:0] dec_addr(input logic [31:0] a);
    if (a == word_addr(EISP_OFS_PRIO0)) begin
      return 3'h0;
    end else if (a == word_addr(EISP_OFS_PRIO1)) begin
      return 3'h1;
    end else if (a == word_addr(EISP_OFS_PRIO2)) begin
      return 3'h2;
    end else if (a == word_addr(EISP_OFS_PRIO3)) begin
      return 3'h3;
    end else if (a == word_addr(EISP_OFS_SENSE)) begin
      return 3'h4;
    end else if (a == word_addr(EISP_OFS_STAT)) begin
      return 3'h5;
    end else if (a == word_addr(EISP_OFS_MASK)) begin
      return 3'h6;
    end else begin
      return 3'h7;
    end
  endfunction

  // Pairwise merge: a 1,0 pair is refused and keeps the old pair
  function automatic logic [7:0] prio_merge(input logic [7:0] old, input logic [7:0] nw);
    logic [7:0] r;
    r = nw;
    for (int p = 0; p < 4; p++) begin
      if (nw[2*p+1 -: 2] == 2'b10) begin
        r[2*p+1 -: 2] = old[2*p+1 -: 2];
      end
    end
    return r;
  endfunction

  logic [2:0] sel;
  assign sel = dec_addr(i_paddr);
  assign hit = (sel != 3'h7);

  ////////////////////////////////////////////////////////////////////////////
  // Bus front end
  eisp_apb u_apb (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_pwdata(i_pwdata),
    .i_rdata(rdata),
    .i_hit(hit),
    .o_wr(wr),
    .o_rd(rd),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .o_prdata(o_prdata)
  );

  always_comb begin
    rdata = 8'h00;
    case (sel)
      3'h0: rdata = prio_q[0];
      3'h1: rdata = prio_q[1];
      3'h2: rdata = prio_q[2];
      3'h3: rdata = prio_q[3] | EISP_PRIO3_RO;
      3'h4: rdata = sense_q & EISP_SENSE_WMASK;
      3'h5: rdata = {4'h0, stat_q};
      3'h6: rdata = {4'h0, mask_q};
      default: rdata = 8'h00;
    endcase
  end
  logic unused_rd;
  assign unused_rd = rd;

  ////////////////////////////////////////////////////////////////////////////
  // Pin qualification, one instance per request group
  eisp_sync #(.W(4)) u_pa (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_pin(i_pins.porta_low),
    .i_sense(sense_q[EISP_PAF_SENSE_LSB +: 2]),
    .i_invert(sense_q[EISP_PA_POL_BIT]),
    .o_edge(edge_ev[EISP_REQ_PA]),
    .o_level(level_ev[EISP_REQ_PA])
  );
  eisp_sync #(.W(3)) u_pf (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_pin(i_pins.portf_low),
    .i_sense(sense_q[EISP_PAF_SENSE_LSB +: 2]),
    .i_invert(1'b0),
    .o_edge(edge_ev[EISP_REQ_PF]),
    .o_level(level_ev[EISP_REQ_PF])
  );
  eisp_sync #(.W(4)) u_pb (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_pin(i_pins.portb_low),
    .i_sense(sense_q[EISP_PB_SENSE_LSB +: 2]),
    .i_invert(sense_q[EISP_PB_POL_BIT]),
    .o_edge(edge_ev[EISP_REQ_PB]),
    .o_level(level_ev[EISP_REQ_PB])
  );
  eisp_sync #(.W(1)) u_pb4 (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_pin(i_pins.portb_bit4),
    .i_sense(sense_q[EISP_PB_SENSE_LSB +: 2]),
    .i_invert(1'b0),
    .o_edge(edge_ev[EISP_REQ_PB4]),
    .o_level(level_ev[EISP_REQ_PB4])
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and pending state
  logic sense_wr;
  logic [7:0] sense_new;
  logic sense_chg;

  always_comb begin
    sense_wr = wr && (sel == 3'h4);
    sense_new = sense_q;
    // Whole field gated by level 3, polarity bits included
    if (sense_wr && at_level3) begin
      sense_new = wbyte & EISP_SENSE_WMASK;
    end
    sense_chg = (sense_new != sense_q);
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      prio_d[i] = prio_q[i];
      if (wr && (sel == 3'(i))) begin
        prio_d[i] = prio_merge(prio_q[i], wbyte);
      end
    end
    prio_d[3] = prio_d[3] | EISP_PRIO3_RO;
    sense_d = sense_new;
    // Set beats ack; config change wipes stale edges
    pend_d = sense_chg ? 4'h0 : (pend_q & ~i_req_ack);
    pend_d = pend_d | edge_ev;
    stat_d = stat_q;
    if (wr && (sel == 3'h5)) begin
      stat_d = stat_q & ~wbyte[3:0];
    end
    stat_d = stat_d | edge_ev | level_ev;
    mask_d = mask_q;
    if (wr && (sel == 3'h6)) begin
      mask_d = wbyte[3:0];
    end
    // Edges wait in pending until acknowledged; levels pass straight
    req_d.req = pend_d | level_ev;
    req_d.prio = {prio_q[1][3:0], prio_q[0][7:4]};
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < 4; i++) begin
        prio_q[i] <= EISP_PRIO_RST;
      end
      sense_q <= EISP_SENSE_RST;
      pend_q <= 4'h0;
      stat_q <= EISP_STAT_RST;
      mask_q <= EISP_MASK_RST;
      req_q <= '0;
      irq_q <= 1'b0;
    end else begin
      prio_q <= prio_d;
      sense_q <= sense_d;
      pend_q <= pend_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      req_q <= req_d;
      irq_q <= irq_d;
    end
  end

  assign o_ext_req = req_q;
  assign o_irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_sense_gate: assert property (@(posedge i_clock) disable iff (i_rst)
    (sense_wr && !at_level3) |=> $stable(sense_q))
    else $error("sense field written outside level 3");
  a_pol_gate: assert property (@(posedge i_clock) disable iff (i_rst)
    $changed(sense_q[EISP_PB_POL_BIT]) |-> $past(at_level3))
    else $error("polarity changed outside level 3");
  a_resv_zero: assert property (@(posedge i_clock) disable iff (i_rst)
    sense_q[1:0] == 2'b00)
    else $error("reserved sense bits set");
  a_prio3_ones: assert property (@(posedge i_clock) disable iff (i_rst)
    (o_pready && !i_pwrite && sel == 3'h3) |-> o_prdata[7:4] == 4'hf)
    else $error("read-only priority bits not one");
  a_prio_refuse: assert property (@(posedge i_clock) disable iff (i_rst)
    (wr && sel == 3'h0 && wbyte[1:0] == 2'b10) |=> prio_q[0][1:0] == $past(prio_q[0][1:0]))
    else $error("level 0 pair was stored");
  a_pend_clear: assert property (@(posedge i_clock) disable iff (i_rst)
    (sense_chg && edge_ev == 4'h0) |=> pend_q == 4'h0)
    else $error("pending not cleared on config change");
  a_edge_req: assert property (@(posedge i_clock) disable iff (i_rst)
    edge_ev[EISP_REQ_PB4] |=> o_ext_req.req[EISP_REQ_PB4])
    else $error("edge did not raise request");
  a_level_hold: assert property (@(posedge i_clock) disable iff (i_rst)
    level_ev[EISP_REQ_PA] [*2] |=> o_ext_req.req[EISP_REQ_PA])
    else $error("level request dropped");
  a_irq_mask: assert property (@(posedge i_clock) disable iff (i_rst)
    o_irq == |(stat_q & mask_q))
    else $error("interrupt does not follow unmasked status");
  a_sense_land: assert property (@(posedge i_clock) disable iff (i_rst)
    (sense_wr && at_level3) |=> sense_q == $past(wbyte & EISP_SENSE_WMASK))
    else $error("sense write at level 3 was lost");
  a_pa_pol_gate: assert property (@(posedge i_clock) disable iff (i_rst)
    $changed(sense_q[EISP_PA_POL_BIT]) |-> $past(at_level3))
    else $error("port A polarity changed outside level 3");
  a_prio3_fixed: assert property (@(posedge i_clock) disable iff (i_rst)
    prio_q[3][7:4] == 4'hf)
    else $error("read-only priority bits lost");
  a_stat_set: assert property (@(posedge i_clock) disable iff (i_rst)
    edge_ev[EISP_REQ_PB] |=> stat_q[EISP_REQ_PB])
    else $error("edge did not set status");
  a_ack_clear: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_req_ack[EISP_REQ_PB4] && !edge_ev[EISP_REQ_PB4]) |=> !pend_q[EISP_REQ_PB4])
    else $error("acknowledged request still pending");
  a_ready_pulse: assert property (@(posedge i_clock) disable iff (i_rst)
    o_pready |=> !o_pready)
    else $error("ready held past the access cycle");
  a_err_unmapped: assert property (@(posedge i_clock) disable iff (i_rst)
    (o_pready && i_psel && !hit) |-> o_pslverr)
    else $error("unmapped access without error");

endmodule
`default_nettype wire

/* File: verilog/eisp_pkg.sv */
// Package: register map, field layout, reset values and carrier types
package eisp_pkg;

  localparam logic [31:0] EISP_OFS_PRIO0 = 32'h0000_0024;
  localparam logic [31:0] EISP_OFS_PRIO1 = 32'h0000_0025;
  localparam logic [31:0] EISP_OFS_PRIO2 = 32'h0000_0026;
  localparam logic [31:0] EISP_OFS_PRIO3 = 32'h0000_0027;
  localparam logic [31:0] EISP_OFS_SENSE = 32'h0000_0028;
  localparam logic [31:0] EISP_OFS_STAT = 32'h0000_0029;
  localparam logic [31:0] EISP_OFS_MASK = 32'h0000_002a;

  localparam logic [7:0] EISP_PRIO_RST = 8'hff;
  localparam logic [7:0] EISP_SENSE_RST = 8'h00;
  localparam logic [3:0] EISP_STAT_RST = 4'h0;
  localparam logic [3:0] EISP_MASK_RST = 4'h0;
  localparam logic [7:0] EISP_PRIO3_RO = 8'hf0;

  localparam int EISP_PB_SENSE_LSB = 6;
  localparam int EISP_PB_POL_BIT = 5;
  localparam int EISP_PAF_SENSE_LSB = 3;
  localparam int EISP_PA_POL_BIT = 2;
  localparam logic [7:0] EISP_SENSE_WMASK = 8'hfc;

  // Request index within the four-request vector
  localparam int EISP_REQ_PA = 0;
  localparam int EISP_REQ_PF = 1;
  localparam int EISP_REQ_PB = 2;
  localparam int EISP_REQ_PB4 = 3;

  typedef struct packed {
    logic [3:0] porta_low;
    logic [2:0] portf_low;
    logic [3:0] portb_low;
    logic portb_bit4;
  } eisp_pins_t;

  typedef struct packed {
    logic [3:0] req;
    logic [7:0] prio;
  } eisp_req_t;

endpackage

/* File: verilog/eisp_sync.sv */
// Two-flop synchroniser and edge/level qualifier for one pin group
`timescale 1ns/100ps
`default_nettype none
module eisp_sync #(
  parameter int W = 4
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [W-1:0] i_pin,
  input wire logic [1:0] i_sense,
  input wire logic i_invert,
  output logic o_edge,
  output logic o_level
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;
  logic [W-1:0] ev_edge;
  logic [W-1:0] ev_level;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= '1;
      sync_q <= '1;
      prev_q <= '1;
    end else begin
      meta_q <= i_pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Code 11 takes both edges whatever the polarity bit says
  function automatic logic qual_edge(input logic [1:0] s, input logic inv, input logic r, input logic f);
    logic q;
    q = r | f;
    case (s)
      2'b00: q = inv ? r : f;
      2'b01: q = inv ? f : r;
      2'b10: q = inv ? r : f;
      default: q = r | f;
    endcase
    return q;
  endfunction

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_pin
      logic rise;
      logic fall;
      assign rise = sync_q[g] & ~prev_q[g];
      assign fall = ~sync_q[g] & prev_q[g];
      assign ev_edge[g] = qual_edge(i_sense, i_invert, rise, fall);
      assign ev_level[g] = (i_sense == 2'b00) && (sync_q[g] == i_invert);
    end
  endgenerate

  // Each pin qualified alone, then merged
  assign o_edge = |ev_edge;
  assign o_level = |ev_level;
endmodule
`default_nettype wire

/* File: verilog/eisp_apb.sv */
// APB slave front end: setup/access decode, one wait-free access
`timescale 1ns/100ps
`default_nettype none
module eisp_apb (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_pwdata,
  input wire logic [7:0] i_rdata,
  input wire logic i_hit,
  output logic o_wr,
  output logic o_rd,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata
);
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic access;

  assign access = i_psel & ~i_penable;
  // Answer in the access cycle from a flop; write takes effect at its end
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_wr = i_psel & i_penable & i_pwrite & i_hit;
  assign o_rd = access & ~i_pwrite;
  assign o_prdata = prdata_q;

  always_comb begin
    prdata_d = prdata_q;
    pready_d = access;
    pslverr_d = access & ~i_hit;
    if (access & ~i_pwrite) begin
      prdata_d = {24'h00_0000, i_rdata};
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end
  logic unused_wdata;
  assign unused_wdata = ^i_pwdata;
endmodule
`default_nettype wire

/* File: bench/eisp_pin_model.sv */
// Behavioural model of the port pins and the CPU core around the block
`timescale 1ns/100ps
`default_nettype none
module eisp_pin_model
  import eisp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire eisp_pins_t i_pin_cmd,
  input wire logic [1:0] i_level_cmd,
  input wire eisp_req_t i_req,
  output var eisp_pins_t o_pins,
  output var logic [1:0] o_cpu_level,
  output var logic [3:0] o_req_ack
);
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      // Pins idle high as with pull-ups, matching the synchroniser reset
      o_pins <= '1;
      o_cpu_level <= 2'h3;
      o_req_ack <= 4'h0;
    end else begin
      // Pins change on a clock edge, never between edges
      o_pins <= i_pin_cmd;
      // Level moves only on a software command, interrupts off while editing
      o_cpu_level <= i_level_cmd;
      // Core takes a request one cycle after it shows
      o_req_ack <= i_req.req;
    end
  end
endmodule
`default_nettype wire

/* File: bench/ext_irq_sensitivity_priority_regs_test.sv */
// Self-checking testbench for sensitivity, priority and request logic
`timescale 1ns/100ps
`default_nettype none
module ext_irq_sensitivity_priority_regs_test;
  import eisp_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, irq, err;
  eisp_pins_t pin_cmd = '1;
  eisp_pins_t pins;
  logic [1:0] lvl_cmd = 2'h3;
  logic [1:0] cpu_level;
  logic [3:0] ack;
  eisp_req_t ext_req;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;

  always #12.5 i_clock = ~i_clock;

  eisp_top dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_pins(pins), .i_req_ack(ack), .i_cpu_level(cpu_level), .o_ext_req(ext_req), .o_irq(irq));
  eisp_pin_model model_u (.i_clock(i_clock), .i_rst(i_rst), .i_pin_cmd(pin_cmd), .i_level_cmd(lvl_cmd),
    .i_req(ext_req), .o_pins(pins), .o_cpu_level(cpu_level), .o_req_ack(ack));

  ////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (n_mismatch == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Entered just after a rising edge; one idle cycle after, so no double drive
  task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    // Register index to byte address
    paddr <= {addr[29:0], 2'b00};
    pwdata <= wd;
    @(posedge i_clock);
    pen <= 1'b1;
    @(posedge i_clock);
    while (pready !== 1'b1) @(posedge i_clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge i_clock);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  function automatic logic eh(int c, logic p, logic r);
    return (c == 3) || ((c == 1) == (r ^ p));
  endfunction

  function automatic logic lv(int c, logic p, logic pin);
    return (c == 0) && (pin == p);
  endfunction

  // Settle time covers model flop, synchroniser and history stage
  task automatic set_pins(input bit grp_b, input logic v);
    if (grp_b) begin
      pin_cmd.portb_low[1] <= v;
      pin_cmd.portb_bit4 <= v;
    end else begin
      pin_cmd.porta_low[2] <= v;
      pin_cmd.portf_low[1] <= v;
    end
    repeat (10) @(posedge i_clock);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset_map();
    for (int i = 0; i < 4; i++) rdc(EISP_OFS_PRIO0 + 32'(i), 32'hff);
    rdc(EISP_OFS_SENSE, 32'h0);
    chk({24'h0, ext_req.prio}, 32'hff);
    rdc(32'h2c, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask

  task automatic t_prio();
    wr(EISP_OFS_PRIO1, 32'hcf);
    wr(EISP_OFS_PRIO1, 32'h64);
    rdc(EISP_OFS_PRIO1, 32'h44);
    wr(EISP_OFS_PRIO3, 32'h00);
    rdc(EISP_OFS_PRIO3, 32'hf0);
    wr(EISP_OFS_PRIO0, 32'h32);
    rdc(EISP_OFS_PRIO0, 32'h33);
    chk({24'h0, ext_req.prio}, 32'h43);
  endtask

  // Port B bit 4 on both edges: request rises, then the core model acks it
  task automatic t_req();
    logic seen;
    seen = 1'b0;
    pin_cmd.portb_bit4 <= 1'b1;
    repeat (8) begin
      @(posedge i_clock);
      seen = seen | ext_req.req[EISP_REQ_PB4];
    end
    chk({31'h0, seen}, 32'h1);
    chk({28'h0, ext_req.req}, 32'h0);
  endtask

  task automatic t_gate();
    for (int l = 0; l < 3; l++) begin
      lvl_cmd <= 2'(l);
      repeat (3) @(posedge i_clock);
      wr(EISP_OFS_SENSE, 32'he4);
      rdc(EISP_OFS_SENSE, 32'h0);
    end
    lvl_cmd <= 2'h3;
    repeat (3) @(posedge i_clock);
    wr(EISP_OFS_SENSE, 32'he4);
    rdc(EISP_OFS_SENSE, 32'he4);
  endtask

  // Invertible pin and fixed-polarity pin of one group move together
  task automatic t_sense(input bit grp_b);
    logic [1:0] e;
    int sh;
    sh = grp_b ? 2 : 0;
    for (int c = 0; c < 4; c++) begin
      for (int p = 0; p < 2; p++) begin
        set_pins(grp_b, 1'b0);
        wr(EISP_OFS_SENSE, grp_b ? 32'(c * 64 + p * 32) : 32'(c * 8 + p * 4));
        wr(EISP_OFS_STAT, 32'hf);
        set_pins(grp_b, 1'b1);
        e = {lv(c, 0, 0) | eh(c, 0, 1) | lv(c, 0, 1), lv(c, p[0], 0) | eh(c, p[0], 1) | lv(c, p[0], 1)};
        apb(1'b0, EISP_OFS_STAT, 32'h0);
        chk(32'((rd >> sh) & 32'h3), {30'h0, e});
        wr(EISP_OFS_STAT, 32'hf);
        set_pins(grp_b, 1'b0);
        e = {lv(c, 0, 1) | eh(c, 0, 0) | lv(c, 0, 0), lv(c, p[0], 1) | eh(c, p[0], 0) | lv(c, p[0], 0)};
        apb(1'b0, EISP_OFS_STAT, 32'h0);
        chk(32'((rd >> sh) & 32'h3), {30'h0, e});
      end
    end
  endtask

  // Status bit 2 is left set by the both-edges case
  task automatic t_irq();
    chk({31'h0, irq}, 32'h0);
    wr(EISP_OFS_MASK, 32'h4);
    @(posedge i_clock);
    chk({31'h0, irq}, 32'h1);
    wr(EISP_OFS_STAT, 32'h4);
    @(posedge i_clock);
    chk({31'h0, irq}, 32'h0);
    wr(EISP_OFS_MASK, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    t_reset_map();
    t_prio();
    t_gate();
    t_sense(1'b1);
    t_irq();
    t_req();
    t_sense(1'b0);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    t_reset_map();
    close_out();
  end

  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles >= 5000) begin
      n_mismatch++;
      close_out();
    end
  end
endmodule
`default_nettype wire
